//--- floppy_regs_map.vh
`ifndef FLOPPY_REGS_MAP_VH
`define FLOPPY_REGS_MAP_VH

// Register addresses on the three-bit host port
`define DATA_PORT_ADDR   3'h5
`define STATUS_RATE_ADDR 3'h7

// Rate code field and reset values
`define RATE_LSB         0
`define RATE_MSB         1
`define RATE_HW_RESET    2'h2
`define NOPREC_BIT       2
`define NOPREC_RESET     1'h0
`define MEDIA_PIN_IDLE   1'b1

// Interface modes presented by the configuration logic
`define MODE_BASIC       2'h0
`define MODE_SECOND      2'h1
`define MODE_THIRD       2'h2

// Fixed fields of the input status byte
`define STAT_ONES_36     4'hF
`define STAT_ZEROS_46    3'h0
`define OEN_BASIC        8'h7F
`define OEN_ALL_DRIVEN   8'h00
`define BYTE_ZERO        8'h00

// Data FIFO geometry and threshold
`define FIFO_DEPTH       16
`define FIFO_AW          4
`define THRESH_W         4
`define THRESH_RESET     4'h0
`define THRESH_MIN       4'h1
`define NONFIFO_LIMIT    5'h01

// Fixed service overhead taken from each latency budget
`define SVC_OVERHEAD_NS  1500
`define CLK_PERIOD_NS    4
`define SVC_OVERHEAD_CYC ((`SVC_OVERHEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- byte_fifo.v
`include "floppy_regs_map.vh"

module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire             mclk,
  input  wire             flush,
  input  wire             push,
  input  wire [WIDTH-1:0] pushData,
  input  wire             pop,
  output wire [WIDTH-1:0] popData,
  output wire [AW:0]      count,
  output wire             empty
);

  reg  [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg  [AW-1:0]    wrPtr_ff;
  reg  [AW-1:0]    rdPtr_ff;
  reg  [AW:0]      count_ff;
  wire             doPush;
  wire             doPop;

  assign empty   = (count_ff == {(AW+1){1'b0}});
  assign doPop   = pop && !empty;
  // Caller limits pushes to its own capacity; this guard only protects storage
  assign doPush  = push && (count_ff != DEPTH[AW:0]);
  assign popData = mem_ff[rdPtr_ff];
  assign count   = count_ff;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : gEntry
      always @(posedge mclk) begin
        if (doPush && (wrPtr_ff == i[AW-1:0])) begin
          mem_ff[i] <= pushData;
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (flush) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_ff + 1'b1;
      end
      count_ff <= count_ff + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
    end
  end

endmodule

//--- input_status_mux.v
`include "floppy_regs_map.vh"

module input_status_mux (
  input  wire [1:0] ifMode,
  input  wire       mediaChangedSync,
  input  wire       forceMediaChange,
  input  wire [1:0] rateCode,
  input  wire       noPrecBit,
  input  wire       dmaGateBit,
  output reg  [7:0] statusByte,
  output reg  [7:0] statusOeN
);

  wire mediaChangedBit;
  wire lowDensityIndicator;

  // Pin is active low on the cable, so the bit shows it inverted
  assign mediaChangedBit = !mediaChangedSync || forceMediaChange;
  // 500K (00) and 1M (11) read low; 300K (01) and 250K (10) read high
  assign lowDensityIndicator = rateCode[`RATE_LSB] ^ rateCode[`RATE_MSB];

  always @* begin
    statusByte = `BYTE_ZERO;
    statusOeN  = `OEN_ALL_DRIVEN;
    case (ifMode)
      `MODE_SECOND: begin
        statusByte = {mediaChangedBit, `STAT_ONES_36, rateCode, lowDensityIndicator};
      end
      `MODE_THIRD: begin
        statusByte = {mediaChangedBit, `STAT_ZEROS_46, dmaGateBit, noPrecBit, rateCode};
      end
      default: begin
        // Low seven lines float in the basic mode
        statusByte = {mediaChangedBit, 7'h00};
        statusOeN  = `OEN_BASIC;
      end
    endcase
  end

endmodule

//--- floppy_host_regs.v
// Function
// - Byte data port at offset five
// - Any reset returns port to non-FIFO mode
// - Configure command enables FIFO and threshold
// - Threshold sets host service latency budget
// - FIFO inactive during command phase; host obeys flags
// - Entering execution flushes FIFO contents
// - Overrun or underrun terminates command and transfer
// - Underrun on write pads sector with zeros
// - Offset seven: status on read, rate on write
// - Basic mode status read drives bit seven only
// - Bit seven is inverted media-changed, forceable
// - Second mode bit zero shows low density
// - Second mode shows rate code, ones above
// - Third mode bit three mirrors DMA gate
// - Third mode bit two mirrors no-precompensation
// - Rate code survives soft reset, hard reset 250K
// - Rate config bits zero-one set rate; rest ignored
// - Third mode stores no-precomp bit, soft reset keeps
// - Latest rate write from either register wins
// - Port accessed only with request flag set
`include "floppy_regs_map.vh"

module floppy_host_regs #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       swRst,
  input  wire [2:0] addr,
  input  wire [7:0] wrData,
  input  wire       wrStrobe,
  input  wire       rdStrobe,
  output wire [7:0] rdData,
  output wire [7:0] rdDataOeN,
  input  wire [1:0] ifMode,
  input  wire       mediaChangedPin,
  input  wire       forceMediaChange,
  input  wire       dmaGateBit,
  input  wire       dsrRateWr,
  input  wire [1:0] dsrRateData,
  input  wire       cfgLoad,
  input  wire       cfgFifoOn,
  input  wire [3:0] cfgThresh,
  input  wire       coreDir,
  input  wire       execStart,
  input  wire       execDone,
  input  wire       coreWrValid,
  input  wire [7:0] coreWrData,
  input  wire       coreTake,
  output wire [7:0] coreTxData,
  input  wire       padSectorDone,
  output wire       hostRequestFlag,
  output wire       transferDirectionFlag,
  output wire [1:0] rateSel,
  output wire       noPrec,
  output wire       fifoActive,
  output wire       xferTerminated,
  output wire       overrunUnderrun,
  output wire       zeroFill,
  output wire       resultPhaseOk
);

  localparam ST_CMD   = 4'b0001;
  localparam ST_EXEC  = 4'b0010;
  localparam ST_DRAIN = 4'b0100;
  localparam ST_FILL  = 4'b1000;

  // Full level of the FIFO at the width of its count
  localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

  reg  [3:0]          state_ff;
  reg  [3:0]          nxt_state;
  reg  [1:0]          rateSel_ff;
  reg                 noPrec_ff;
  reg                 fifoOn_ff;
  reg  [`THRESH_W-1:0] thresh_ff;
  reg                 errFlag_ff;
  reg  [7:0]          rdData_ff;
  reg  [7:0]          rdOeN_ff;
  reg  [7:0]          coreTx_ff;
  reg  [7:0]          nxt_rdData;
  reg  [7:0]          nxt_rdOeN;
  reg  [7:0]          nxt_coreTx;
  reg                 medSync1_ff;
  reg                 medSync2_ff;

  wire [7:0]    statusByte;
  wire [7:0]    statusOeN;
  wire [7:0]    fifoHead;
  wire [AW:0]   fifoCount;
  wire          fifoEmpty;
  wire          anyReset;
  wire          flush;
  wire [AW:0]   limit;
  wire [AW:0]   threshEff;
  wire          fullEff;
  wire          readReq;
  wire          writeReq;
  wire          dirOut;
  wire          dataWr;
  wire          dataRd;
  wire          rateWr;
  wire          hostPush;
  wire          hostPop;
  wire          corePush;
  wire          corePop;
  wire          overrun;
  wire          underrun;
  wire          inExec;
  wire          statusRd;
  wire          padByte;
  wire          fifoPush;
  wire          fifoPop;
  wire [7:0]    fifoIn;

  assign anyReset = sys_rst || swRst;
  assign inExec   = (state_ff == ST_EXEC);

  // Media-changed pin comes from the cable and is resynchronised first
  always @(posedge mclk) begin
    if (sys_rst) begin
      medSync1_ff <= `MEDIA_PIN_IDLE;
      medSync2_ff <= `MEDIA_PIN_IDLE;
    end else begin
      medSync1_ff <= mediaChangedPin;
      medSync2_ff <= medSync1_ff;
    end
  end

  // Address decode; data port strobes act only while the request flag allows
  assign dataWr = wrStrobe && (addr == `DATA_PORT_ADDR);
  assign dataRd = rdStrobe && (addr == `DATA_PORT_ADDR);
  assign rateWr = wrStrobe && (addr == `STATUS_RATE_ADDR);
  assign statusRd = rdStrobe && (addr == `STATUS_RATE_ADDR);

  // Configure command state; any reset falls back to single-byte operation
  always @(posedge mclk) begin
    if (anyReset) begin
      fifoOn_ff <= 1'b0;
      thresh_ff <= `THRESH_RESET;
    end else if (cfgLoad) begin
      fifoOn_ff <= cfgFifoOn;
      thresh_ff <= cfgThresh;
    end
  end

  // An enabled FIFO is bypassed only in the command phase
  assign fifoActive = fifoOn_ff && (state_ff != ST_CMD);
  assign limit      = fifoActive ? FULL_COUNT : `NONFIFO_LIMIT;
  assign threshEff  = (thresh_ff < `THRESH_MIN) ? {{(AW+1-`THRESH_W){1'b0}}, `THRESH_MIN}
                                                : {{(AW+1-`THRESH_W){1'b0}}, thresh_ff};
  assign fullEff    = (fifoCount >= limit);

  // Direction is frozen to controller-to-host while draining
  assign dirOut = (state_ff == ST_DRAIN) ? 1'b1 : coreDir;

  // Request early: leave threshold bytes of room or of stock, so the host
  // has threshold byte-times minus the fixed overhead to answer
  assign readReq  = !fifoEmpty &&
                    (!fifoActive || (fifoCount >= limit - threshEff) ||
                     (state_ff == ST_DRAIN));
  assign writeReq = !fullEff && (state_ff != ST_FILL) && (state_ff != ST_DRAIN) &&
                    (!fifoActive || (fifoCount <= threshEff));

  assign hostRequestFlag       = dirOut ? readReq : writeReq;
  assign transferDirectionFlag = dirOut;

  // Host accesses without the request flag are dropped
  assign hostPush = dataWr && !dirOut && hostRequestFlag;
  assign hostPop  = dataRd && dirOut && hostRequestFlag;

  // Controller side: bytes from disk arrive, bytes to disk leave
  assign corePush = coreWrValid && dirOut && !fullEff &&
                    (state_ff != ST_DRAIN);
  assign corePop  = coreTake && !dirOut && !fifoEmpty &&
                    (state_ff != ST_FILL);

  // Service misses only count while data moves in the execution phase
  assign overrun  = inExec && coreWrValid && coreDir && fullEff;
  assign underrun = inExec && coreTake && !coreDir && fifoEmpty;

  // Stale bytes never cross into a new execution phase
  assign flush = anyReset || execStart;

  // Host and disk side never move bytes the same way at once, so one port serves both
  assign fifoPush = hostPush || corePush;
  assign fifoPop  = hostPop || corePop;
  assign fifoIn   = dirOut ? coreWrData : wrData;

  byte_fifo #(
    .WIDTH    (8),
    .DEPTH    (DEPTH),
    .AW       (AW)
  ) uFifo (
    .mclk     (mclk),
    .flush    (flush),
    .push     (fifoPush),
    .pushData (fifoIn),
    .pop      (fifoPop),
    .popData  (fifoHead),
    .count    (fifoCount),
    .empty    (fifoEmpty)
  );

  // Phase tracking
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_CMD: begin
        if (execStart) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (overrun) begin
          nxt_state = ST_DRAIN;
        end else if (underrun) begin
          nxt_state = ST_FILL;
        end else if (execDone) begin
          nxt_state = ST_CMD;
        end
      end
      ST_DRAIN: begin
        // Result phase waits until the host has emptied the FIFO
        if (fifoEmpty) begin
          nxt_state = ST_CMD;
        end
      end
      ST_FILL: begin
        if (padSectorDone) begin
          nxt_state = ST_CMD;
        end
      end
      default: begin
        nxt_state = ST_CMD;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (anyReset) begin
      state_ff <= ST_CMD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Error flag for the status bytes; a new miss in the start cycle still sets it
  always @(posedge mclk) begin
    if (anyReset) begin
      errFlag_ff <= 1'b0;
    end else if (overrun || underrun) begin
      errFlag_ff <= 1'b1;
    end else if (execStart) begin
      errFlag_ff <= 1'b0;
    end
  end

  assign xferTerminated  = (state_ff == ST_DRAIN) || (state_ff == ST_FILL);
  assign overrunUnderrun = errFlag_ff;
  assign zeroFill        = (state_ff == ST_FILL);
  assign resultPhaseOk   = (state_ff == ST_DRAIN) ? fifoEmpty : 1'b1;

  // Byte to the disk side; zeros stand in once the host has fallen behind
  assign padByte = (state_ff == ST_FILL) || underrun;

  always @* begin
    nxt_coreTx = coreTx_ff;
    if (coreTake) begin
      if (padByte) begin
        nxt_coreTx = `BYTE_ZERO;
      end else if (corePop) begin
        nxt_coreTx = fifoHead;
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      coreTx_ff <= `BYTE_ZERO;
    end else begin
      coreTx_ff <= nxt_coreTx;
    end
  end

  assign coreTxData = coreTx_ff;

  // Rate code: hard reset only; the latest of either register wins
  always @(posedge mclk) begin
    if (sys_rst) begin
      rateSel_ff <= `RATE_HW_RESET;
    end else if (rateWr) begin
      rateSel_ff <= wrData[`RATE_MSB:`RATE_LSB];
    end else if (dsrRateWr) begin
      rateSel_ff <= dsrRateData;
    end
  end

  // No-precompensation bit is kept only in the third mode and drives noPrec and third-mode status bit two
  always @(posedge mclk) begin
    if (sys_rst) begin
      noPrec_ff <= `NOPREC_RESET;
    end else if (rateWr && (ifMode == `MODE_THIRD)) begin
      noPrec_ff <= wrData[`NOPREC_BIT];
    end
  end

  assign rateSel = rateSel_ff;
  assign noPrec  = noPrec_ff;

  input_status_mux uStatus (
    .ifMode           (ifMode),
    .mediaChangedSync (medSync2_ff),
    .forceMediaChange (forceMediaChange),
    .rateCode         (rateSel_ff),
    .noPrecBit        (noPrec_ff),
    .dmaGateBit       (dmaGateBit),
    .statusByte       (statusByte),
    .statusOeN        (statusOeN)
  );

  // Read data appear in the cycle after the strobe only; idle bus reads zero
  // so a late sample can never pick up a stale byte
  always @* begin
    nxt_rdData = `BYTE_ZERO;
    nxt_rdOeN  = `OEN_ALL_DRIVEN;
    if (statusRd) begin
      nxt_rdData = statusByte;
      nxt_rdOeN  = statusOeN;
    end else if (hostPop) begin
      nxt_rdData = fifoHead;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      rdData_ff <= `BYTE_ZERO;
      rdOeN_ff  <= `OEN_ALL_DRIVEN;
    end else begin
      rdData_ff <= nxt_rdData;
      rdOeN_ff  <= nxt_rdOeN;
    end
  end

  assign rdData    = rdData_ff;
  assign rdDataOeN = rdOeN_ff;

endmodule

//--- floppy_host_regs_properties.sv
module floppy_host_regs_properties (
  input wire       mclk,
  input wire       sys_rst,
  input wire       swRst,
  input wire [2:0] addr,
  input wire [7:0] wrData,
  input wire       wrStrobe,
  input wire       rdStrobe,
  input wire [7:0] rdData,
  input wire [7:0] rdDataOeN,
  input wire [1:0] ifMode,
  input wire       forceMediaChange,
  input wire       dmaGateBit,
  input wire       dsrRateWr,
  input wire       coreTake,
  input wire [7:0] coreTxData,
  input wire [1:0] rateSel,
  input wire       noPrec,
  input wire       zeroFill
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  rate_write_a: assert property (
    wrStrobe && addr == 3'h7 |=> rateSel == $past(wrData[1:0]))
    else $error("rate write lost");
  soft_keep_a: assert property (
    swRst && !wrStrobe && !dsrRateWr |=> $stable(rateSel) && $stable(noPrec))
    else $error("soft reset changed rate");
  basic_oen_a: assert property (
    rdStrobe && addr == 3'h7 && ifMode == 2'h0 |=> rdDataOeN == 8'h7F)
    else $error("basic status enables wrong");
  second_layout_a: assert property (
    rdStrobe && addr == 3'h7 && ifMode == 2'h1
    |=> rdData[6:0] == {4'hF, $past(rateSel), ^$past(rateSel)})
    else $error("second layout wrong");
  third_layout_a: assert property (
    rdStrobe && addr == 3'h7 && ifMode == 2'h2
    |=> rdData[6:0] == {3'h0, $past(dmaGateBit), $past(noPrec), $past(rateSel)})
    else $error("third layout wrong");
  force_change_a: assert property (
    rdStrobe && addr == 3'h7 && forceMediaChange |=> rdData[7])
    else $error("forced change bit low");
  read_idle_a: assert property (
    !rdStrobe |=> rdData == 8'h00 && rdDataOeN == 8'h00)
    else $error("read data outside read slot");
  zero_pad_a: assert property (
    zeroFill && coreTake |=> coreTxData == 8'h00)
    else $error("pad byte not zero");
endmodule

bind floppy_host_regs floppy_host_regs_properties i_props (.*);

//--- host_bus_model.sv
module host_bus_model (
  input  wire        mclk,
  input  wire  [7:0] rdData,
  input  wire        hostRequestFlag,
  output logic [2:0] addr,
  output logic [7:0] wrData,
  output logic       wrStrobe,
  output logic       rdStrobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr     = 3'h0;
    wrData   = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
  end
  // An idle cycle follows each strobe, so back-to-back calls never clash
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    int n;
    n = 0;
    while (a == 3'h5 && hostRequestFlag !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    addr     <= a;
    wrData   <= v;
    wrStrobe <= 1'b1;
    @(posedge mclk);
    wrStrobe <= 1'b0;
    wrData   <= ~v;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    int n;
    n = 0;
    // Bounded wait: a stuck flag still ends in a refused read
    while (a == 3'h5 && hostRequestFlag !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    @(posedge mclk);
    v = rdData;
  endtask
endmodule

//--- floppy_host_data_and_rate_regs_tb.sv
module floppy_host_data_and_rate_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] mode;
    logic       dma;
    logic [7:0] wr;
    logic [7:0] exp;
    logic [7:0] oen;
    logic [7:0] mask;
  } row_t;
  logic       mclk, sys_rst, swRst, wrStrobe, rdStrobe, mediaChangedPin;
  logic       forceMediaChange, dmaGateBit, dsrRateWr, cfgLoad, cfgFifoOn, coreDir;
  logic       execStart, execDone, coreWrValid, coreTake, padSectorDone, hostRequestFlag;
  logic       transferDirectionFlag, noPrec, fifoActive, xferTerminated, overrunUnderrun;
  logic       zeroFill, resultPhaseOk;
  logic [1:0] ifMode, dsrRateData, rateSel;
  logic [2:0] addr;
  logic [3:0] cfgThresh;
  logic [7:0] wrData, rdData, rdDataOeN, coreWrData, coreTxData, d;
  int         miscompares, nCompared, cyc;
  row_t       rows [7] = '{
    '{2'h0, 1'b0, 8'hFE, 8'h80, 8'h7F, 8'h80},
    '{2'h1, 1'b0, 8'h00, 8'hF8, 8'h00, 8'hFF},
    '{2'h1, 1'b0, 8'hFD, 8'hFB, 8'h00, 8'hFF},
    '{2'h1, 1'b1, 8'h03, 8'hFE, 8'h00, 8'hFF},
    '{2'h1, 1'b0, 8'h02, 8'hFD, 8'h00, 8'hFF},
    '{2'h2, 1'b1, 8'h05, 8'h8D, 8'h00, 8'hFF},
    '{2'h2, 1'b0, 8'hFA, 8'h82, 8'h00, 8'hFF}
  };

  host_bus_model   i_host (.*);
  floppy_host_regs i_dut (.*);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic push(input logic [7:0] b);
    coreWrValid <= 1'b1;
    coreWrData  <= b;
    tick(1);
    coreWrValid <= 1'b0;
    tick(1);
  endtask

  task automatic close_out();
    $display("compared %0d, mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    {swRst, mediaChangedPin, forceMediaChange, dmaGateBit, dsrRateWr, cfgLoad} = 6'h00;
    {cfgFifoOn, coreDir, execStart, execDone, coreWrValid, coreTake} = 6'h00;
    {padSectorDone, ifMode, dsrRateData, cfgThresh} = 9'h000;
    coreWrData = 8'h00;
    sys_rst = 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      ifMode     <= rows[i].mode;
      dmaGateBit <= rows[i].dma;
      i_host.wr(3'h7, rows[i].wr);
      i_host.rd(3'h7, d);
      check(d & rows[i].mask, rows[i].exp);
      check(rdDataOeN, rows[i].oen);
      check(rateSel, rows[i].wr[1:0]);
    end
    $display("test layouts finished");
    i_host.wr(3'h7, 8'h07);
    swRst <= 1'b1;
    tick(1);
    swRst <= 1'b0;
    tick(1);
    check(rateSel, 2'h3);
    check(noPrec, 1'b1);
    sys_rst <= 1'b1;
    tick(1);
    sys_rst <= 1'b0;
    tick(1);
    check(rateSel, 2'h2);
    check(noPrec, 1'b0);
    dsrRateWr   <= 1'b1;
    dsrRateData <= 2'h1;
    tick(1);
    dsrRateWr <= 1'b0;
    tick(1);
    check(rateSel, 2'h1);
    i_host.wr(3'h7, 8'h00);
    check(rateSel, 2'h0);
    $display("test resets and rate finished");
    mediaChangedPin <= 1'b1;
    tick(3);
    i_host.rd(3'h7, d);
    check(d[7], 1'b0);
    forceMediaChange <= 1'b1;
    i_host.rd(3'h7, d);
    check(d[7], 1'b1);
    i_host.rd(3'h0, d);
    check(d, 8'h00);
    $display("test change bit finished");
    cfgFifoOn <= 1'b1;
    cfgThresh <= 4'h8;
    cfgLoad   <= 1'b1;
    coreDir   <= 1'b1;
    tick(1);
    cfgLoad <= 1'b0;
    push(8'hEE);
    check(fifoActive, 1'b0);
    execStart <= 1'b1;
    tick(1);
    execStart <= 1'b0;
    for (int i = 0; i < 7; i++)
      push(8'h10 + 8'(i));
    check(hostRequestFlag, 1'b0);
    check(fifoActive, 1'b1);
    push(8'h17);
    check(hostRequestFlag, 1'b1);
    check(transferDirectionFlag, 1'b1);
    push(8'h18);
    for (int i = 0; i < 2; i++) begin
      i_host.rd(3'h5, d);
      check(d, 8'h10 + 8'(i));
    end
    execDone <= 1'b1;
    tick(1);
    execDone  <= 1'b0;
    execStart <= 1'b1;
    tick(1);
    execStart <= 1'b0;
    for (int i = 0; i < 17; i++)
      push(8'h20 + 8'(i));
    check(overrunUnderrun, 1'b1);
    check(xferTerminated, 1'b1);
    check(resultPhaseOk, 1'b0);
    for (int i = 0; i < 16; i++) begin
      i_host.rd(3'h5, d);
      check(d, 8'h20 + 8'(i));
    end
    check(resultPhaseOk, 1'b1);
    execDone <= 1'b1;
    tick(1);
    execDone <= 1'b0;
    $display("test data port finished");
    coreDir   <= 1'b0;
    execStart <= 1'b1;
    tick(1);
    execStart <= 1'b0;
    i_host.wr(3'h5, 8'h5A);
    check(hostRequestFlag, 1'b1);
    check(transferDirectionFlag, 1'b0);
    check(overrunUnderrun, 1'b0);
    coreTake <= 1'b1;
    tick(1);
    coreTake <= 1'b0;
    tick(1);
    check(coreTxData, 8'h5A);
    coreTake  <= 1'b1;
    tick(1);
    coreTake <= 1'b0;
    tick(1);
    check(zeroFill, 1'b1);
    check(xferTerminated, 1'b1);
    check(overrunUnderrun, 1'b1);
    coreTake <= 1'b1;
    tick(1);
    coreTake <= 1'b0;
    tick(1);
    check(coreTxData, 8'h00);
    padSectorDone <= 1'b1;
    tick(1);
    padSectorDone <= 1'b0;
    tick(1);
    check(zeroFill, 1'b0);
    swRst <= 1'b1;
    tick(1);
    swRst     <= 1'b0;
    execStart <= 1'b1;
    tick(1);
    execStart <= 1'b0;
    tick(1);
    check(fifoActive, 1'b0);
    $display("test underrun finished");
    close_out();
  end
endmodule
